// File: core/mfr_pkg.sv
/*
 * Shared types and constants for the multifunction terminal router.
 * Assumes one 50 MHz clock; all pin levels are synchronised in the core.
 */
`default_nettype none
package mfr_pkg;
    // ------------------------------------------------------------------
    // terminal functions and their legality per terminal
    // ------------------------------------------------------------------
    typedef enum logic [3:0] {
        FN_INPUT, FN_PCI_INT, FN_GPI, FN_GPO, FN_SKT, FN_VIDEO, FN_AUDIO,
        FN_GPE, FN_IRQ, FN_DMA_REQ, FN_SER_IRQ, FN_LOCK, FN_DMA_GNT,
        FN_CLKRUN, FN_RING
    } mfr_fn_e;

    localparam int PIN_N   = 7;
    localparam int GP_N    = 5;
    localparam int FIELD_W = 4;
    localparam int ROUTE_W = PIN_N * FIELD_W;
    // bit k set: function code k is legal on that terminal
    localparam logic [15:0] FN_MASK [PIN_N] = '{
        16'h01ff, 16'h01fd, 16'h43ed, 16'h0501, 16'h49fd, 16'h11fd,
        16'h2101};
    // which general input/output line each terminal carries
    localparam int GP_IDX [PIN_N] = '{0, 1, 2, 0, 3, 4, 0};

    // ------------------------------------------------------------------
    // synchroniser bank layout
    // ------------------------------------------------------------------
    localparam int SY_BUS_RST_N = 7;
    localparam int SY_SUSPEND_N = 8;
    localparam int SY_STRAP_A   = 9;
    localparam int SY_STRAP_B   = 10;
    localparam int SY_RING      = 11;
    localparam int SY_SPK       = 12;

    // ------------------------------------------------------------------
    // serial EEPROM loader timing and framing
    // ------------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 20;
    localparam int SCL_PERIOD_NS = 10000;
    localparam int QTR_CYC = (SCL_PERIOD_NS / 4 + CLK_PERIOD_NS - 1)
                             / CLK_PERIOD_NS;
    localparam int DIV_W    = 8;
    localparam int EE_BYTES = 6;
    localparam int EE_W     = EE_BYTES * 8;
    localparam logic [7:0]  EE_DEV_WR  = 8'ha0;
    localparam logic [7:0]  EE_DEV_RD  = 8'ha1;
    localparam logic [7:0]  EE_WORD    = 8'h00;
    localparam logic [3:0]  ACK_BIT    = 4'h8;
    localparam logic [1:0]  LAST_PHASE = 2'h3;
    localparam logic [ROUTE_W-1:0] ROUTING_RST = 28'h0000000;
    localparam logic [15:0] SUBSYS_RST = 16'h0000;

    typedef enum logic [2:0] {
        LD_IDLE, LD_START, LD_TX, LD_RX, LD_STOP
    } mfr_ld_e;

    // ------------------------------------------------------------------
    // carriers to and from the internal core logic
    // ------------------------------------------------------------------
    typedef struct packed {
        logic             int_a;      // parallel interrupt A request
        logic [GP_N-1:0]  gpo;        // general outputs
        logic             socket_act; // a socket is busy
        logic             video_sw;   // video port switch level
        logic [PIN_N-1:0] irq;        // parallel IRQ level per terminal
        logic             dma_req;
        logic             serirq_drv; // pull serialized interrupt low
        logic             clkrun_drv; // pull clock-run low
        logic             pme;        // power management event
        logic             ring_is_pme;// ring output carries pme
    } mfr_core_in_s;

    typedef struct packed {
        logic [GP_N-1:0]  gpi;
        logic [PIN_N-1:0] general_event;        // level of each terminal in event mode
        logic             lock_n;
        logic             dma_gnt_n;
        logic             serirq_n;
        logic             clkrun_n;
    } mfr_core_out_s;

    typedef struct packed {
        logic [ROUTE_W-1:0] routing;
        logic [15:0]        subsys;
        logic               serial_mode;
        logic               bus_ok_d;
        mfr_ld_e            ld_st;
        logic               busy;
        logic [1:0]         phase;
        logic [DIV_W-1:0]   div;
        logic [3:0]         bitcnt;
        logic [2:0]         bytecnt;
        logic [EE_W-1:0]    ee_data;
        logic               sda_low;
        logic               scl;
        logic [PIN_N-1:0]   pin_o;
        logic [PIN_N-1:0]   pin_oe;
        mfr_core_out_s      core_o;
        logic               speaker;
        logic               skt_led;
        logic               ring_out;
    } mfr_state_s;

    localparam mfr_state_s STATE_RST = '0;
endpackage : mfr_pkg

// File: core/mfr_router.sv
/*
 * Multifunction terminal router with speaker, activity and ring outputs
 * and a two-wire EEPROM loader for register defaults.
 * Assumes the core logic shares CLOCK_I and the pads resolve the
 * output enables; all pad inputs arrive asynchronously.
 */
// Overview of operation
// - terminal 0: int A, gp 0 in/out, activity, video, audio, event, IRQ
// - terminal 1: gp 1 in/out, activity, video, audio, event, IRQ
// - both straps high after bus reset: terminal 1 is serial data
// - after bus reset in serial mode, load defaults from the EEPROM
// - terminal 2: DMA request, gp 2, video, audio, event, ring, IRQ
// - terminal 3: parallel IRQ or serialized interrupt
// - terminal 4: lock, gp 3, activity, video, audio, event, ring, IRQ
// - terminal 5: DMA grant, gp 4, activity, video, audio, event, IRQ
// - terminal 6: clock-run or parallel IRQ
// - host speaker is the XOR of the card speaker inputs
// - suspend keeps registers through global and bus reset
// - socket activity output follows socket activity
// - ring output carries ring indicate or power event
`timescale 1ns/100ps
`default_nettype none
module mfr_router
    import mfr_pkg::*;
#(
    parameter int NSOCK = 2
) (
    // clock and reset
    input  wire logic                 CLOCK_I,
    input  wire logic                 SYS_RST_I,
    // pins from outside
    input  wire logic                 BUS_RST_N_I,
    input  wire logic                 SUSPEND_N_I,
    input  wire logic                 SERIAL_STRAP_A_I,
    input  wire logic                 SERIAL_STRAP_B_I,
    input  wire logic                 CARD_RING_I,
    input  wire logic [NSOCK-1:0]     CARD_SPEAKER_I,
    input  wire logic [PIN_N-1:0]     MULTI_PIN_I,
    // terminal drive
    output var  logic [PIN_N-1:0]     MULTI_PIN_O,
    output var  logic [PIN_N-1:0]     MULTI_PIN_OE_O,
    output var  logic                 SERIAL_CLK_O,
    output var  logic                 HOST_SPEAKER_O,
    output var  logic                 SOCKET_ACTIVITY_O,
    output var  logic                 RING_INDICATE_O,
    // core side
    input  wire mfr_core_in_s         CORE_I,
    output var  mfr_core_out_s        CORE_O,
    input  wire logic                 ROUTING_WR_I,
    input  wire logic [ROUTE_W-1:0]   ROUTING_I,
    output var  logic [ROUTE_W-1:0]   ROUTING_O,
    output var  logic [15:0]          SUBSYS_ID_O,
    output var  logic                 SERIAL_MODE_O,
    output var  logic                 LOAD_BUSY_O
);
    localparam int SY_W = SY_SPK + NSOCK;

    mfr_state_s      r, n;
    logic [SY_W-1:0] sy;

    initial begin
        if (NSOCK < 1 || NSOCK > 4) $error("mfr_router: NSOCK out of range");
    end

    // -------------------------------------------------------------------
    // helpers
    // -------------------------------------------------------------------
    function automatic logic fn_ok(input int pin, input logic [3:0] code);
        return FN_MASK[pin][code];
    endfunction : fn_ok

    function automatic logic [7:0] tx_byte(input logic [2:0] idx);
        return (idx == 3'h0) ? EE_DEV_WR :
               (idx == 3'h1) ? EE_WORD : EE_DEV_RD;
    endfunction : tx_byte

    // every pad level crosses two flops before use
    mfr_sync #(.W(SY_W)) u_sync (
        .CLOCK_I (CLOCK_I),
        .ASYNC_I ({CARD_SPEAKER_I, CARD_RING_I, SERIAL_STRAP_B_I,
                   SERIAL_STRAP_A_I, SUSPEND_N_I, BUS_RST_N_I,
                   MULTI_PIN_I}),
        .SYNC_O  (sy)
    );

    // -------------------------------------------------------------------
    // next state
    // -------------------------------------------------------------------
    always_comb begin
        logic    tick;
        logic    last;
        logic [7:0] txb;
        mfr_fn_e fn;
        tick  = (r.div == '0);
        last  = (r.bytecnt == 3'(EE_BYTES - 1));
        txb   = 8'h00;
        fn    = FN_INPUT;
        n     = r;
        if (SYS_RST_I || !sy[SY_BUS_RST_N]) begin
            n = STATE_RST;
            n.scl = 1'b1;
            if (!sy[SY_SUSPEND_N]) begin
                n.routing     = r.routing;
                n.subsys      = r.subsys;
                n.serial_mode = r.serial_mode;
            end
            n.bus_ok_d = sy[SY_BUS_RST_N] & r.bus_ok_d;
        end else begin
            // writes from the core are ignored while defaults load
            if (ROUTING_WR_I && !r.busy) begin
                n.routing = ROUTING_I;
            end
            // straps are looked at once, on the release of bus reset
            if (!r.bus_ok_d) begin
                n.bus_ok_d    = 1'b1;
                n.serial_mode = sy[SY_STRAP_A] & sy[SY_STRAP_B];
                if (sy[SY_STRAP_A] && sy[SY_STRAP_B]) begin
                    n.ld_st   = LD_START;
                    n.busy    = 1'b1;
                    n.phase   = '0;
                    n.bytecnt = '0;
                    n.div     = DIV_W'(QTR_CYC - 1);
                end
            end
            // eeprom loader: four ticks to a bit cell
            if (r.ld_st != LD_IDLE && tick) begin
                n.div   = DIV_W'(QTR_CYC - 1);
                n.phase = r.phase + 2'h1;
                if (r.ld_st == LD_RX && r.phase == 2'h1 &&
                    r.bitcnt != ACK_BIT) begin
                    n.ee_data = {r.ee_data[EE_W-2:0], sy[1]};
                end
                if (r.phase == LAST_PHASE) begin
                    unique case (r.ld_st)
                        LD_START: begin
                            n.ld_st  = LD_TX;
                            n.bitcnt = '0;
                        end
                        LD_TX: begin
                            n.bitcnt = r.bitcnt + 4'h1;
                            if (r.bitcnt == ACK_BIT) begin
                                n.bitcnt  = '0;
                                n.bytecnt = r.bytecnt + 3'h1;
                                if (r.bytecnt == 3'h1) begin
                                    n.ld_st = LD_START;  // repeated start
                                end else if (r.bytecnt == 3'h2) begin
                                    n.ld_st   = LD_RX;
                                    n.bytecnt = '0;
                                end
                            end
                        end
                        LD_RX: begin
                            n.bitcnt = r.bitcnt + 4'h1;
                            if (r.bitcnt == ACK_BIT) begin
                                n.bitcnt  = '0;
                                n.bytecnt = r.bytecnt + 3'h1;
                                if (last) n.ld_st = LD_STOP;
                            end
                        end
                        LD_STOP: begin
                            n.ld_st   = LD_IDLE;
                            n.busy    = 1'b0;
                            n.subsys  = r.ee_data[EE_W-1:EE_W-16];
                            n.routing = r.ee_data[ROUTE_W-1:0];
                        end
                        LD_IDLE: n.ld_st = LD_IDLE;
                    endcase
                end
            end else if (r.ld_st != LD_IDLE) begin
                n.div = r.div - DIV_W'(1);
            end
            // wire levels follow the cell phase
            txb = tx_byte(n.bytecnt);
            unique case (n.ld_st)
                LD_IDLE:  n.sda_low = 1'b0;
                LD_START: n.sda_low = n.phase[1];
                LD_TX:    n.sda_low = (n.bitcnt != ACK_BIT) &&
                                      !txb[3'(7 - int'(n.bitcnt[2:0]))];
                LD_RX:    n.sda_low = (n.bitcnt == ACK_BIT) &&
                                      (n.bytecnt != 3'(EE_BYTES - 1));
                LD_STOP:  n.sda_low = !n.phase[1];
            endcase
            n.scl = (n.ld_st == LD_IDLE) ||
                    (n.ld_st == LD_STOP && n.phase != 2'h0) ||
                    (n.phase == 2'h1) || (n.phase == 2'h2);
            // terminal multiplexer
            n.core_o = '{gpi: '0, general_event: '0, default: 1'b1};
            for (int i = 0; i < PIN_N; i++) begin
                fn = fn_ok(i, r.routing[i*FIELD_W +: FIELD_W]) ?
                     mfr_fn_e'(r.routing[i*FIELD_W +: FIELD_W]) :
                     FN_INPUT;
                n.pin_o[i]  = 1'b0;
                n.pin_oe[i] = 1'b0;
                unique case (fn)
                    FN_PCI_INT: n.pin_oe[i] = CORE_I.int_a;
                    FN_GPO: begin
                        n.pin_o[i]  = CORE_I.gpo[GP_IDX[i]];
                        n.pin_oe[i] = 1'b1;
                    end
                    FN_SKT: begin
                        n.pin_o[i]  = CORE_I.socket_act;
                        n.pin_oe[i] = 1'b1;
                    end
                    FN_VIDEO: begin
                        n.pin_o[i]  = CORE_I.video_sw;
                        n.pin_oe[i] = 1'b1;
                    end
                    FN_AUDIO: begin
                        n.pin_o[i]  = ^sy[SY_SPK +: NSOCK];
                        n.pin_oe[i] = 1'b1;
                    end
                    FN_IRQ: begin
                        n.pin_o[i]  = CORE_I.irq[i];
                        n.pin_oe[i] = 1'b1;
                    end
                    FN_DMA_REQ: begin
                        n.pin_o[i]  = CORE_I.dma_req;
                        n.pin_oe[i] = 1'b1;
                    end
                    FN_RING: begin
                        n.pin_o[i]  = CORE_I.ring_is_pme ?
                                      CORE_I.pme : sy[SY_RING];
                        n.pin_oe[i] = 1'b1;
                    end
                    FN_SER_IRQ: begin
                        n.pin_oe[i]       = CORE_I.serirq_drv;
                        n.core_o.serirq_n = sy[i];
                    end
                    FN_CLKRUN: begin
                        n.pin_oe[i]       = CORE_I.clkrun_drv;
                        n.core_o.clkrun_n = sy[i];
                    end
                    FN_GPI:     n.core_o.gpi[GP_IDX[i]] = sy[i];
                    FN_GPE:     n.core_o.general_event[i] = sy[i];
                    FN_LOCK:    n.core_o.lock_n = sy[i];
                    FN_DMA_GNT: n.core_o.dma_gnt_n = sy[i];
                    FN_INPUT:   n.pin_oe[i] = 1'b0;
                endcase
            end
            // serial data replaces whatever terminal 1 was routed to
            if (r.serial_mode) begin
                n.pin_o[1]  = 1'b0;
                n.pin_oe[1] = n.sda_low;
            end
            n.speaker  = ^sy[SY_SPK +: NSOCK];
            n.skt_led  = CORE_I.socket_act;
            n.ring_out = CORE_I.ring_is_pme ? CORE_I.pme
                                            : sy[SY_RING];
        end
    end

    always_ff @(posedge CLOCK_I) begin
        r <= n;
    end

    // -------------------------------------------------------------------
    // outputs
    // -------------------------------------------------------------------
    assign MULTI_PIN_O       = r.pin_o;
    assign MULTI_PIN_OE_O    = r.pin_oe;
    assign SERIAL_CLK_O      = r.scl;
    assign HOST_SPEAKER_O    = r.speaker;
    assign SOCKET_ACTIVITY_O = r.skt_led;
    assign RING_INDICATE_O   = r.ring_out;
    assign CORE_O            = r.core_o;
    assign ROUTING_O         = r.routing;
    assign SUBSYS_ID_O       = r.subsys;
    assign SERIAL_MODE_O     = r.serial_mode;
    assign LOAD_BUSY_O       = r.busy;

    // -------------------------------------------------------------------
    // assertions
    // -------------------------------------------------------------------
    default clocking cb @(posedge CLOCK_I); endclocking
    default disable iff (SYS_RST_I || !sy[SY_BUS_RST_N]);

    sequence s_bus_release;
        !r.bus_ok_d && sy[SY_BUS_RST_N] && !SYS_RST_I;
    endsequence
    sequence s_straps_high;
        sy[SY_STRAP_A] && sy[SY_STRAP_B];
    endsequence

    property p_int_a;
        r.routing[3:0] == 4'(FN_PCI_INT) |=>
            MULTI_PIN_OE_O[0] == $past(CORE_I.int_a) && !MULTI_PIN_O[0];
    endproperty
    a_int_a: assert property (p_int_a) else $error("int A drive wrong");
    property p_illegal;
        !fn_ok(6, r.routing[27:24]) |=> !MULTI_PIN_OE_O[6];
    endproperty
    a_illegal: assert property (p_illegal) else $error("bad pick drives");
    property p_serirq;
        r.routing[15:12] == 4'(FN_SER_IRQ) |=>
            MULTI_PIN_OE_O[3] == $past(CORE_I.serirq_drv);
    endproperty
    a_serirq: assert property (p_serirq) else $error("serirq drive");
    property p_clkrun;
        r.routing[27:24] == 4'(FN_CLKRUN) |=>
            CORE_O.clkrun_n == $past(sy[6]);
    endproperty
    a_clkrun: assert property (p_clkrun) else $error("clkrun level");
    property p_speaker;
        1'b1 |=> HOST_SPEAKER_O == $past(^sy[SY_SPK +: NSOCK]);
    endproperty
    a_speaker: assert property (p_speaker) else $error("speaker xor");
    property p_suspend;
        disable iff (1'b0)
        (SYS_RST_I && !sy[SY_SUSPEND_N]) |=> $stable(ROUTING_O)
            && $stable(SUBSYS_ID_O);
    endproperty
    a_suspend: assert property (p_suspend) else $error("suspend lost");
    property p_socket;
        CORE_I.socket_act |=> SOCKET_ACTIVITY_O;
    endproperty
    a_socket: assert property (p_socket) else $error("no activity");
    property p_ring;
        CORE_I.ring_is_pme |=> RING_INDICATE_O == $past(CORE_I.pme);
    endproperty
    a_ring: assert property (p_ring) else $error("ring source");
    property p_load_start;
        s_bus_release ##0 s_straps_high |=> LOAD_BUSY_O && SERIAL_MODE_O
            ##1 !SERIAL_CLK_O [*3];
    endproperty
    a_load_start: assert property (p_load_start) else $error("no load");
    property p_sda_pin;
        r.serial_mode |=> MULTI_PIN_OE_O[1] == r.sda_low;
    endproperty
    a_sda_pin: assert property (p_sda_pin) else $error("sda pin");
endmodule : mfr_router
`default_nettype wire

// File: core/mfr_sync.sv
/*
 * Two-stage synchroniser bank for asynchronous pin levels.
 * Assumes inputs are levels; the first stage feeds only the second.
 */
`timescale 1ns/100ps
`default_nettype none
module mfr_sync #(
    parameter int W = 1
) (
    // clock
    input  wire logic         CLOCK_I,
    // levels in and out
    input  wire logic [W-1:0] ASYNC_I,
    output var  logic [W-1:0] SYNC_O
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } mfr_sync_s;

    mfr_sync_s r, n;

    initial begin
        if (W < 1) $error("mfr_sync: width must be at least one");
    end

    // data pipeline only, no reset: reset would drop the suspend level
    always_comb begin
        n.s1 = ASYNC_I;
        n.s2 = r.s1;
    end

    always_ff @(posedge CLOCK_I) begin
        r <= n;
    end

    assign SYNC_O = r.s2;
endmodule : mfr_sync
`default_nettype wire

// File: tb/mfr_host_pads.sv
/*
 * host-side pad model: host drivers and pull-ups on the seven terminals.
 * assumes the bench changes host drive levels between clock edges.
 */
`timescale 1ns/100ps
`default_nettype none
module mfr_host_pads
    import mfr_pkg::*;
(
    // design pad drive
    input  wire logic [PIN_N-1:0] PIN_O_I,
    input  wire logic [PIN_N-1:0] PIN_OE_I,
    // host drive
    input  wire logic [PIN_N-1:0] HOST_V_I,
    input  wire logic [PIN_N-1:0] HOST_OE_I,
    // resolved level
    output var  logic [PIN_N-1:0] PAD_O
);
    // released pads go to the pull-up, so an unacked read gives ones
    always_comb begin
        for (int i = 0; i < PIN_N; i++) begin
            PAD_O[i] = PIN_OE_I[i] ? PIN_O_I[i]
                     : (HOST_OE_I[i] ? HOST_V_I[i] : 1'b1);
        end
    end
endmodule : mfr_host_pads
`default_nettype wire

// File: tb/test_multifunction_terminal_routing.sv
/*
 * self-checking bench for the terminal router: routing sweep, random
 * routes, suspend through reset, and a serial default load.
 * assumes the host pad model resolves the terminal levels.
 */
`timescale 1ns/100ps
`default_nettype none
module test_multifunction_terminal_routing
    import mfr_pkg::*;
;
    logic clk = 0, rst = 1, brst_n = 0, susp_n = 1, sa = 0, sb = 0;
    logic ring = 0, wr = 0, scl, hspk, sact, rio, smode, busy;
    logic [1:0]         spk = 0;
    logic [PIN_N-1:0]   pad, po, poe, hv = 0, hoe = 0;
    logic [ROUTE_W-1:0] rin = 0, rout;
    logic [15:0]        sub;
    logic [3:0]         code [PIN_N];
    mfr_core_in_s       ci = '0;
    mfr_core_out_s      co;
    int                 bad_count = 0, comparisons = 0, n;

    always #10 clk = ~clk;

    mfr_router u_mfr_router (.CLOCK_I(clk), .SYS_RST_I(rst),
        .BUS_RST_N_I(brst_n), .SUSPEND_N_I(susp_n), .SERIAL_STRAP_A_I(sa),
        .SERIAL_STRAP_B_I(sb), .CARD_RING_I(ring), .CARD_SPEAKER_I(spk),
        .MULTI_PIN_I(pad), .MULTI_PIN_O(po), .MULTI_PIN_OE_O(poe),
        .SERIAL_CLK_O(scl), .HOST_SPEAKER_O(hspk), .SOCKET_ACTIVITY_O(sact),
        .RING_INDICATE_O(rio), .CORE_I(ci), .CORE_O(co), .ROUTING_WR_I(wr),
        .ROUTING_I(rin), .ROUTING_O(rout), .SUBSYS_ID_O(sub),
        .SERIAL_MODE_O(smode), .LOAD_BUSY_O(busy));
    mfr_host_pads u_mfr_host_pads (.PIN_O_I(po), .PIN_OE_I(poe),
        .HOST_V_I(hv), .HOST_OE_I(hoe), .PAD_O(pad));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic summarize;
        if (bad_count == 0 && comparisons > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : summarize

    task automatic cyc(input int k);
        repeat (k) @(negedge clk);
    endtask : cyc

    // {check value, enable, value}; audio and ring carry unknown data
    function automatic logic [2:0] ex(int i, int c, mfr_core_in_s k);
        if (!FN_MASK[i][c]) return 3'b000;
        case (c)
            1:       return {1'b1, k.int_a, 1'b0};
            3:       return {2'b11, k.gpo[GP_IDX[i]]};
            4:       return {2'b11, k.socket_act};
            5:       return {2'b11, k.video_sw};
            8:       return {2'b11, k.irq[i]};
            9:       return {2'b11, k.dma_req};
            10:      return {1'b1, k.serirq_drv, 1'b0};
            13:      return {1'b1, k.clkrun_drv, 1'b0};
            6, 14:   return 3'b010;
            default: return 3'b000;
        endcase
    endfunction : ex

    // write code[], randomise core and pad levels, then check every pin
    task automatic route_chk;
        logic [2:0] e;
        for (int i = 0; i < PIN_N; i++) rin[4*i+:4] = code[i];
        ci = mfr_core_in_s'($bits(mfr_core_in_s)'($urandom));
        hv = PIN_N'($urandom);
        hoe = PIN_N'($urandom);
        spk = 2'($urandom);
        ring = 1'($urandom);
        wr = 1;
        cyc(1);
        wr = 0;
        cyc(4);
        chk(rout, rin);
        chk(hspk, ^spk);
        chk(sact, ci.socket_act);
        chk(rio, ci.ring_is_pme ? ci.pme : ring);
        for (int i = 0; i < PIN_N; i++) begin
            e = ex(i, code[i], ci);
            chk(poe[i], e[1]);
            if (e[2]) chk(po[i], e[0]);
            if (code[i] == 7 && FN_MASK[i][7]) chk(co.general_event[i], pad[i]);
            if (code[i] == 2 && FN_MASK[i][2])
                chk(co.gpi[GP_IDX[i]], pad[i]);
            if (code[i] == 10 && i == 3) chk(co.serirq_n, pad[i]);
            if (code[i] == 11 && i == 4) chk(co.lock_n, pad[i]);
            if (code[i] == 12 && i == 5) chk(co.dma_gnt_n, pad[i]);
            if (code[i] == 13 && i == 6) chk(co.clkrun_n, pad[i]);
        end
    endtask : route_chk

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        void'($urandom(55204));
        // bus reset with the global one, so the strap latch starts known
        cyc(4);
        brst_n = 1;
        cyc(2);
        rst = 0;
        cyc(1);
        // every code on every terminal, then random mixes
        for (int c = 0; c < 16; c++) begin
            foreach (code[i]) code[i] = 4'(c);
            route_chk();
        end
        repeat (40) begin
            foreach (code[i]) code[i] = 4'($urandom);
            route_chk();
        end
        // suspended resets keep routing, a plain reset clears it
        susp_n = 0;
        cyc(3);
        rst = 1;
        cyc(2);
        rst = 0;
        brst_n = 0;
        cyc(4);
        brst_n = 1;
        cyc(5);
        chk(rout, rin);
        chk(smode, 0);
        susp_n = 1;
        cyc(3);
        rst = 1;
        cyc(2);
        rst = 0;
        cyc(2);
        chk(rout, 0);
        // straps high at bus reset release start the default load
        hoe = 0;
        sa = 1;
        sb = 1;
        cyc(3);
        brst_n = 0;
        cyc(4);
        brst_n = 1;
        for (n = 0; busy !== 1 && n < 20; n++) cyc(1);
        chk(busy, 1);
        chk(smode, 1);
        if (busy !== 1) summarize();
        // a write during the load is dropped
        rin = ROUTE_W'($urandom);
        wr = 1;
        cyc(1);
        wr = 0;
        cyc(2);
        chk(rout, 0);
        for (n = 0; busy === 1 && n < 60000; n++) cyc(1);
        chk(busy, 0);
        if (busy !== 0) summarize();
        // nobody answers, so the pull-up reads back all ones
        chk(sub, 16'hffff);
        chk(rout, 28'hfffffff);
        chk(poe[0], 0);
        chk(scl, 1);
        summarize();
    end
endmodule : test_multifunction_terminal_routing
`default_nettype wire
